/* File: include/cfg_reader_params.svh */
// constants of the serial configuration bitstream reader
`ifndef CFG_READER_PARAMS_SVH
`define CFG_READER_PARAMS_SVH

`define CLK_PERIOD_NS    40
`define POR_TIME_NS      2000
`define POR_CYCLES       ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MEM_DEPTH_BITS   65536
`define LOW_BLOCK_BITS   8192
`define GUARD_BLOCK_BITS 8192
`define FIFO_DEPTH       32
`define FIFO_WIDTH       1

`define PIN_COUNT        8
`define PIN_SCLK         0
`define PIN_CS_N         1
`define PIN_ROE          2
`define PIN_MODE_N       3
`define PIN_WP           4
`define PIN_WPP          5
`define PIN_DSEL         6
`define PIN_DATA         7

`endif

/* File: include/cfg_reader_pkg.sv */
// types of the serial configuration bitstream reader
package cfg_reader_pkg;
    typedef enum logic [1:0] {
        ST_PRIME,
        ST_SHIFT,
        ST_DONE,
        ST_PROG
    } read_state_type;
endpackage

/* File: rtl/serial_config_bitstream_reader.sv */
// bitstream readout logic with its prefetch fifo
`timescale 1ns/10ps
`include "cfg_reader_params.svh"

module cfg_bit_fifo #(
    parameter int WIDTH = `FIFO_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PW:0]      wr_ptr_q;
    logic [PW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wr_ptr_q - rd_ptr_q) != (PW+1)'(DEPTH);
    assign out_valid_o = wr_ptr_q != rd_ptr_q;
    assign out_data_o  = store_q[rd_ptr_q[PW-1:0]];
    assign push        = in_valid_i & in_ready_o & ~flush_i;
    assign pop         = out_valid_o & out_ready_i & ~flush_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            store_q[wr_ptr_q[PW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (flush_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + (PW+1)'(push);
            rd_ptr_q <= rd_ptr_q + (PW+1)'(pop);
        end
    end
endmodule

// Contract
// - Reset level on reset/output-enable clears the counter and floats data.
// - Chip select high after reset keeps counter stopped and data floating.
// - Chip select low enables the counter and the data driver.
// - A new reset clears and floats whatever chip select does.
// - After the last bit, with cascade low, the data pin floats.
// - Power-up clears the address counter without an external reset.
// - Each serial clock rising edge advances and presents the next bit.
// - Count only when enabled and unfinished; a master otherwise pulls clock low.
// - During reset the master stops and drives the clock pin low.
// - Reset/output-enable polarity is selectable; default is reset low.
// - Reset/output-enable acts only while mode select is high.
// - Write guard high blocks programming writes to the lowest block.
// - Portion guard protects memory only when programming, default inactive.
// - Chip select sampled at reset picks master or subsequent device.
// - Cascade output goes low on the first clock rise after the counter reaches its maximum.
// - Device select qualifies programming only, default low.
// - Ready is held low during power-on reset, released afterwards.
// - Mode select low enters programming; high is needed for loading.
// - Data is three-state for readout, open-collector when programming.
// - Store is one bit wide, depth set by the variant.
// - The edge after the last bit asserts cascade and drops the driver.
// - Chip select high means standby with data floating.
module serial_config_bitstream_reader
    import cfg_reader_pkg::*;
#(
    parameter int DEPTH      = `MEM_DEPTH_BITS,
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int POR_CYCLES = `POR_CYCLES,
    parameter int AW         = $clog2(DEPTH)
) (
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          serial_bit_clock_i,
    input  wire logic          chip_select_n_i,
    input  wire logic          reset_oe_i,
    input  wire logic          program_mode_select_n_i,
    input  wire logic          write_guard_low_i,
    input  wire logic          write_guard_portion_i,
    input  wire logic          program_device_select_i,
    input  wire logic          reset_polarity_i,
    input  wire logic          data_i,
    input  wire logic          prog_wr_i,
    input  wire logic [AW-1:0] prog_addr_i,
    input  wire logic          prog_data_i,
    input  wire logic          prog_pull_low_i,
    output logic               data_o,
    output logic               data_oe_o,
    output logic               serial_bit_clock_o,
    output logic               serial_bit_clock_oe_o,
    output logic               chain_next_select_n_o,
    output logic               ready_o,
    output logic               ready_oe_o,
    output logic               prog_line_o
);
    import cfg_reader_pkg::*;

    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
    localparam int            LOW_END   = `LOW_BLOCK_BITS;
    localparam int            GUARD_LO  = DEPTH - `GUARD_BLOCK_BITS;
    localparam int            CW        = $clog2(POR_CYCLES + 1);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [`PIN_COUNT-1:0] pin_raw;
    logic [`PIN_COUNT-1:0] pin_s1_q;
    logic [`PIN_COUNT-1:0] pin_s2_q;
    logic                  sclk_prev_q;

    assign pin_raw = {data_i, program_device_select_i,
                      write_guard_portion_i, write_guard_low_i,
                      program_mode_select_n_i, reset_oe_i,
                      chip_select_n_i, serial_bit_clock_i};

    for (genvar g = 0; g < `PIN_COUNT; g++) begin : g_sync
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                pin_s1_q[g] <= 1'b0;
                pin_s2_q[g] <= 1'b0;
            end else begin
                pin_s1_q[g] <= pin_raw[g];
                pin_s2_q[g] <= pin_s1_q[g];
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= pin_s2_q[`PIN_SCLK];
        end
    end

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    logic           sclk_rise;
    logic           cs_n;
    logic           mode_n;
    logic           reset_active;
    logic           powered_q;
    logic [CW-1:0]  por_cnt_q;
    logic           master_q;
    read_state_type state_q;
    logic [AW-1:0]  bit_cnt_q;
    logic           at_last;
    logic           adv;
    logic           go;
    logic           flush;
    logic           count_ok;

    assign sclk_rise = pin_s2_q[`PIN_SCLK] & ~sclk_prev_q;
    assign cs_n      = pin_s2_q[`PIN_CS_N];
    assign mode_n    = pin_s2_q[`PIN_MODE_N];
    assign reset_active = mode_n & (pin_s2_q[`PIN_ROE] == reset_polarity_i);
    assign flush     = reset_active | ~powered_q | ~mode_n;
    assign at_last   = bit_cnt_q == LAST_ADDR;
    assign count_ok  = ~flush & ~cs_n & (state_q != ST_DONE);
    assign adv       = count_ok & (state_q == ST_SHIFT) & sclk_rise;

    // ------------------------------------------------------------
    // power-on reset and ready indicator
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            por_cnt_q <= '0;
            powered_q <= 1'b0;
        end else if (por_cnt_q == CW'(POR_CYCLES - 1)) begin
            powered_q <= 1'b1;
        end else begin
            por_cnt_q <= por_cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ready_o    <= 1'b0;
            ready_oe_o <= 1'b1;
        end else begin
            ready_o    <= 1'b0;
            ready_oe_o <= ~powered_q;
        end
    end

    // ------------------------------------------------------------
    // chain position strap
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            master_q <= 1'b0;
        end else if (~powered_q | reset_active) begin
            master_q <= ~cs_n;
        end
    end

    // ------------------------------------------------------------
    // bit store and programming writes
    // ------------------------------------------------------------
    logic          mem_q [DEPTH];
    logic          guard_hit;
    logic          mem_we;
    logic [AW:0]   fill_addr_q;
    logic          fill_valid;
    logic          fill_ready;
    logic          fifo_valid;
    logic          fifo_bit;

    assign guard_hit = (pin_s2_q[`PIN_WP]
                        & (int'(prog_addr_i) < LOW_END))
                     | (pin_s2_q[`PIN_WPP]
                        & (int'(prog_addr_i) >= GUARD_LO));
    assign mem_we = prog_wr_i & ~mode_n & ~cs_n
                  & pin_s2_q[`PIN_DSEL] & ~guard_hit;

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem_q[prog_addr_i] <= prog_data_i;
        end
    end

    assign fill_valid = ~flush & (fill_addr_q < (AW+1)'(DEPTH));

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fill_addr_q <= '0;
        end else if (flush) begin
            fill_addr_q <= '0;
        end else if (fill_valid & fill_ready) begin
            fill_addr_q <= fill_addr_q + (AW+1)'(1);
        end
    end

    cfg_bit_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .flush_i     (flush),
        .in_valid_i  (fill_valid),
        .in_ready_o  (fill_ready),
        .in_data_i   (mem_q[fill_addr_q[AW-1:0]]),
        .out_valid_o (fifo_valid),
        .out_ready_i (go | (adv & ~at_last)),
        .out_data_o  (fifo_bit)
    );

    // ------------------------------------------------------------
    // readout sequence
    // ------------------------------------------------------------
    assign go = ~flush & ~cs_n & (state_q == ST_PRIME) & fifo_valid;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q   <= ST_PRIME;
            bit_cnt_q <= '0;
        end else if (~mode_n) begin
            state_q   <= ST_PROG;
            bit_cnt_q <= '0;
        end else if (flush) begin
            state_q   <= ST_PRIME;
            bit_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_PRIME: if (go) begin
                    state_q <= ST_SHIFT;
                end
                ST_SHIFT: if (adv) begin
                    if (at_last) begin
                        state_q <= ST_DONE;
                    end else begin
                        bit_cnt_q <= bit_cnt_q + AW'(1);
                    end
                end
                ST_DONE: state_q <= ST_DONE;
                ST_PROG: state_q <= ST_PRIME;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_o    <= 1'b0;
            data_oe_o <= 1'b0;
        end else if (~mode_n) begin
            data_o    <= 1'b0;
            data_oe_o <= prog_pull_low_i;
        end else begin
            if (go | (adv & ~at_last)) begin
                data_o <= fifo_bit;
            end
            data_oe_o <= ~flush & ~cs_n
                       & (go | ((state_q == ST_SHIFT)
                       & ~(adv & at_last)));
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chain_next_select_n_o <= 1'b1;
        end else if (flush) begin
            chain_next_select_n_o <= 1'b1;
        end else if (adv & at_last) begin
            chain_next_select_n_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            serial_bit_clock_o    <= 1'b0;
            serial_bit_clock_oe_o <= 1'b0;
        end else begin
            serial_bit_clock_o    <= 1'b0;
            serial_bit_clock_oe_o <= mode_n & master_q & ~count_ok;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_line_o <= 1'b1;
        end else begin
            prog_line_o <= pin_s2_q[`PIN_DATA];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    AST_RESET_CLEARS: assert property (
        reset_active |=> (bit_cnt_q == '0) && !data_oe_o
    ) else $error("reset did not clear counter or float data");

    AST_CS_HIGH_FLOATS: assert property (
        mode_n && cs_n |=> !data_oe_o
    ) else $error("data driven while chip select high");

    AST_CS_LOW_DRIVES: assert property (
        go |=> data_oe_o && (state_q == ST_SHIFT)
    ) else $error("driver not enabled after priming");

    AST_CASC_FLOATS: assert property (
        mode_n && !chain_next_select_n_o |-> !data_oe_o
    ) else $error("data driven after last bit");

    AST_POWERUP_CLEARS: assert property (
        !powered_q |=> (bit_cnt_q == '0) && (state_q != ST_SHIFT)
    ) else $error("counter not cleared at power-up");

    AST_ADVANCE: assert property (
        adv && !at_last |=> bit_cnt_q == $past(bit_cnt_q) + AW'(1)
    ) else $error("counter did not advance on clock edge");

    AST_HOLD_STOPPED: assert property (
        mode_n && !reset_active && cs_n |=> $stable(bit_cnt_q)
    ) else $error("counter moved while deselected");

    AST_MASTER_CLK_LOW: assert property (
        reset_active && master_q |=> serial_bit_clock_oe_o
            && !serial_bit_clock_o
    ) else $error("master did not hold clock low in reset");

    AST_GUARD_BLOCKS: assert property (
        pin_s2_q[`PIN_WP] && (int'(prog_addr_i) < LOW_END) |-> !mem_we
    ) else $error("write reached protected low block");

    AST_CASC_LOW: assert property (
        adv && at_last |=> !chain_next_select_n_o ##1 !data_oe_o
    ) else $error("cascade not asserted after last bit");

    AST_READY_LOW: assert property (
        !powered_q |=> ready_oe_o && !ready_o
    ) else $error("ready released during power-on reset");

    COV_PRIME: cover property (go ##1 data_oe_o);
    COV_ADVANCE: cover property (adv ##[1:20] adv);
    COV_CASCADE: cover property (adv && at_last);
    COV_GUARD: cover property (prog_wr_i && !mode_n && guard_hit);
endmodule

/* File: tb/fpga_serial_loader.sv */
// serial loader model standing in for the configuring fpga
`timescale 1ns/10ps
module fpga_serial_loader (
    input  wire logic data_pin_i,
    output logic      sclk_o
);
    // clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
    end
    // one rise, then sample the pin late in the low phase
    task automatic clock_bit(output logic b);
        sclk_o = 1'b1;
        #160;
        sclk_o = 1'b0;
        #150;
        b = data_pin_i;
        #10;
    endtask
endmodule

/* File: tb/serial_config_bitstream_reader_tb_top.sv */
// testbench for the serial configuration bitstream reader
`timescale 1ns/10ps
module serial_config_bitstream_reader_tb_top;
    import cfg_reader_pkg::*;
    logic       clk_i, sys_rst_i, sclk, cs_n, roe, mode_n, wg_low, wg_por;
    logic       dsel, pol, prog_wr, prog_data, pull_low, b, data_pin;
    logic [5:0] prog_addr;
    logic       data_o, data_oe, sclk_o, sclk_oe, chain_n, rdy_o, rdy_oe;
    logic       prog_line;
    logic       float_q = 1'b0;
    int         bad_count, n_compared, i, k;
    int         cyc = 0;

    // ---------------------------------------------
    // clock, pin resolution, timeout
    // ---------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // released pin shows the inverse of the last driven value
    always @(posedge clk_i) if (data_oe === 1'b1) float_q <= ~data_o;
    assign data_pin = (data_oe === 1'b1) ? data_o : float_q;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    serial_config_bitstream_reader #(.DEPTH(64), .FIFO_DEPTH(32),
        .POR_CYCLES(4), .AW(6)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .serial_bit_clock_i(sclk),
        .chip_select_n_i(cs_n), .reset_oe_i(roe),
        .program_mode_select_n_i(mode_n), .write_guard_low_i(wg_low),
        .write_guard_portion_i(wg_por), .program_device_select_i(dsel),
        .reset_polarity_i(pol), .data_i(data_pin), .prog_wr_i(prog_wr),
        .prog_addr_i(prog_addr), .prog_data_i(prog_data),
        .prog_pull_low_i(pull_low), .data_o(data_o), .data_oe_o(data_oe),
        .serial_bit_clock_o(sclk_o), .serial_bit_clock_oe_o(sclk_oe),
        .chain_next_select_n_o(chain_n), .ready_o(rdy_o),
        .ready_oe_o(rdy_oe), .prog_line_o(prog_line));
    fpga_serial_loader LOADER (.data_pin_i(data_pin), .sclk_o(sclk));

    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    function automatic logic pat(input int a);
        pat = ^(a[5:0] & 6'h25);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic prog_write(input int a, input logic d);
        @(negedge clk_i);
        prog_wr = 1'b1;
        prog_addr = a[5:0];
        prog_data = d;
        @(negedge clk_i);
        prog_wr = 1'b0;
    endtask
    task automatic power_up();
        sys_rst_i = 1'b1;
        cycles(5);
        check({rdy_oe, rdy_o}, 2'h2);
        check(data_oe, 1'b0);
        sys_rst_i = 1'b0;
        cycles(2);
        check(rdy_oe, 1'b1);
        for (k = 0; k < 30 && rdy_oe !== 1'b0; k++) cycles(1);
        check(rdy_oe, 1'b0);
    endtask
    task automatic select_at_zero();
        cs_n = 1'b0;
        cycles(10);
        check(data_oe, 1'b1);
        check(data_pin, pat(0));
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        {sys_rst_i, cs_n, roe, mode_n, wg_low, wg_por} = 6'h24;
        {dsel, pol, prog_wr, prog_data, pull_low} = 5'h00;
        prog_addr = '0;
        bad_count = 0;
        n_compared = 0;
        power_up();
        check(sclk_oe, 1'b1);
        check(sclk_o, 1'b0);
        // programming, guarded and unselected writes dropped
        mode_n = 1'b0;
        dsel = 1'b1;
        cycles(4);
        for (i = 0; i < 64; i++) prog_write(i, pat(i));
        wg_low = 1'b1;
        cycles(3);
        prog_write(5, ~pat(5));
        wg_low = 1'b0;
        wg_por = 1'b1;
        cycles(3);
        prog_write(60, ~pat(60));
        wg_por = 1'b0;
        dsel = 1'b0;
        cycles(3);
        prog_write(9, ~pat(9));
        pull_low = 1'b1;
        cycles(3);
        check({data_oe, data_pin}, 2'h2);
        pull_low = 1'b0;
        cycles(3);
        check(data_oe, 1'b0);
        cycles(1);
        check(prog_line, 1'b1);
        // standby after reset pulse, rises ignored
        mode_n = 1'b1;
        cs_n = 1'b1;
        cycles(6);
        roe = 1'b1;
        cycles(6);
        check({data_oe, chain_n, sclk_oe}, 3'h2);
        LOADER.clock_bit(b);
        LOADER.clock_bit(b);
        cycles(1);
        select_at_zero();
        check(sclk_oe, 1'b0);
        for (i = 1; i < 64; i++) begin
            LOADER.clock_bit(b);
            check(b, pat(i));
        end
        LOADER.clock_bit(b);
        cycles(2);
        check({chain_n, data_oe, sclk_oe}, 3'h0);
        roe = 1'b0;
        cycles(6);
        check({chain_n, data_oe}, 2'h2);
        roe = 1'b1;
        cycles(10);
        check({data_oe, data_pin}, {1'b1, pat(0)});
        for (i = 1; i < 4; i++) begin
            LOADER.clock_bit(b);
            check(b, pat(i));
        end
        cycles(1);
        roe = 1'b0;
        cycles(6);
        check(data_oe, 1'b0);
        check(sclk_oe, 1'b1);
        roe = 1'b1;
        cycles(10);
        check({data_oe, data_pin}, {1'b1, pat(0)});
        // power-up with chip select high: subsequent device
        cs_n = 1'b1;
        power_up();
        cycles(4);
        check(sclk_oe, 1'b0);
        select_at_zero();
        check(sclk_oe, 1'b0);
        // programmed polarity flipped: high level now resets
        pol = 1'b1;
        cycles(3);
        check({data_oe, sclk_oe}, 2'h1);
        roe = 1'b0;
        cycles(10);
        check({data_oe, data_pin}, {1'b1, pat(0)});
        give_verdict();
    end
endmodule
